// >>> rtl/spoa_pkg.sv
/*
 * Shared constants for the sector protection overlay link: geometry,
 * transaction codes, status word layout, reset values and link timing.
 * Assumes both link ends and the bench import it unchanged.
 */
package spoa_pkg;

   // Geometry: 16 sectors of 16 words, word address = {sector, word}
   localparam int ADDR_W      = 8;
   localparam int SECT_W      = 4;
   localparam int NUM_SECT    = 16;
   localparam int WDATA_W     = 8;
   localparam int RDATA_W     = 16;
   localparam int SECT_LSB    = 4;

   // Transaction codes carried on the write data lines
   localparam logic [7:0] KEY1_CODE      = 8'hAA;
   localparam logic [7:0] KEY2_CODE      = 8'h55;
   localparam logic [7:0] LOCK_ENT_CODE  = 8'h58;
   localparam logic [7:0] DYN_ENT_CODE   = 8'hE0;
   localparam logic [7:0] PERS_ENT_CODE  = 8'hC0;
   localparam logic [7:0] EXIT_CODE      = 8'hF0;
   localparam logic [7:0] STATUS_CODE    = 8'h60;
   localparam logic [7:0] PROG_CODE      = 8'hA0;
   localparam logic [7:0] GUARD_SET_DATA = 8'h00;
   localparam logic [7:0] GUARD_CLR_DATA = 8'h01;
   localparam logic [7:0] LOCK_CLR_DATA  = 8'h00;

   // Sector status word bit positions
   localparam int ST_ANY_BIT  = 0;
   localparam int ST_DYN_BIT  = 1;
   localparam int ST_PERS_BIT = 2;
   localparam int ST_HI_LSB   = 3;
   localparam int ST_HI_MSB   = 15;
   localparam int OVL_BIT     = 0;

   // Reset values
   localparam logic [NUM_SECT-1:0] DYN_RESET  = 16'h0000;
   localparam logic                LOCK_RESET = 1'b1;
   localparam logic [15:0]         RDATA_RESET = 16'hFFFF;

   // Link timing: link clock half period in core clocks (40 MHz core)
   localparam int CORE_PERIOD_NS = 25;
   localparam int LINK_HALF_NS   = 200;
   localparam int LINK_HALF_CYC  = LINK_HALF_NS / CORE_PERIOD_NS;
   localparam int DIV_W          = 4;

   // Device overlay modes, command sequence stages and host cycle states
   typedef enum logic [1:0] {MODE_ARRAY, MODE_LOCK, MODE_DYN, MODE_PERS} spoa_mode_e;
   typedef enum logic [2:0] {SQ_IDLE, SQ_KEY1, SQ_KEY2, SQ_PROG, SQ_STATUS} spoa_seq_e;
   typedef enum logic [1:0] {H_IDLE, H_WAIT_LOW, H_DRIVE} spoa_hstate_e;

endpackage : spoa_pkg

// >>> rtl/spoa_link_if.sv
/*
 * Link between the host controller end and the device end.
 * Assumes the host makes the link clock; all lines are plain one-way wires.
 */
`timescale 1ns/1ps
interface spoa_link_if;
   import spoa_pkg::*;

   logic                link_clk;
   logic                cyc_valid;
   logic                cyc_write;
   logic [ADDR_W-1:0]   cyc_addr;
   logic [WDATA_W-1:0]  cyc_wdata;
   logic [RDATA_W-1:0]  cyc_rdata;

   // Host drives the cycle, device answers on read data
   modport host_mp (output link_clk, output cyc_valid, output cyc_write,
                    output cyc_addr, output cyc_wdata, input cyc_rdata);
   modport dev_mp  (input link_clk, input cyc_valid, input cyc_write,
                    input cyc_addr, input cyc_wdata, output cyc_rdata);
endinterface : spoa_link_if

// >>> rtl/spoa_device.sv
/*
 * Device end of the sector protection overlay link: decodes bus cycles
 * into overlay entry, exit, guard bit set and clear, lock clear, reads and
 * the sector status query, and holds the volatile guard bits.
 * Assumes the host owns the link clock and keeps cycle fields stable for a
 * full link clock period around each rising edge.
 */
`timescale 1ns/1ps
module spoa_device
   import spoa_pkg::*;
(
   input  wire logic                          core_clk_in,
   input  wire logic                          nrst_in,
   spoa_link_if.dev_mp                        link,
   input  wire logic [spoa_pkg::NUM_SECT-1:0] pers_guard_in,
   input  wire logic [spoa_pkg::RDATA_W-1:0]  array_rdata_in,
   output logic      [spoa_pkg::ADDR_W-1:0]   array_addr_out,
   output logic                               global_guard_lock_bit_out,
   output logic      [spoa_pkg::NUM_SECT-1:0] volatile_sector_guard_bit_out,
   output logic      [1:0]                    mode_out
);
   import spoa_pkg::*;

   localparam int BUS_W = 3 + ADDR_W + WDATA_W;

   logic [BUS_W-1:0]     sync1_reg;
   logic [BUS_W-1:0]     sync2_reg;
   logic                 clk_last_reg;
   logic                 edge_valid;
   logic                 cyc_write;
   logic [ADDR_W-1:0]    cyc_addr;
   logic [WDATA_W-1:0]   cyc_wdata;
   logic [SECT_W-1:0]    cyc_sect;
   logic                 wr_cyc;
   logic                 rd_cyc;
   spoa_mode_e           mode_reg;
   spoa_seq_e            seq_reg;
   logic [NUM_SECT-1:0]  dyn_reg;
   logic                 lock_reg;
   logic                 fetch_reg;
   logic [RDATA_W-1:0]   rdata_reg;
   logic [RDATA_W-1:0]   status_word;
   logic                 set_hit;
   logic                 clr_hit;

   // Two flops on every link line; only the second stage feeds logic
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else
      begin
         sync1_reg <= {link.link_clk, link.cyc_valid, link.cyc_write,
                       link.cyc_addr, link.cyc_wdata};
         sync2_reg <= sync1_reg;
      end
   end

   // Rising link clock edge detector
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         clk_last_reg <= 1'b0;
      else
         clk_last_reg <= sync2_reg[BUS_W-1];
   end

   // Fields are stable a whole period, so sampling after sync is safe
   assign edge_valid = sync2_reg[BUS_W-1] & ~clk_last_reg & sync2_reg[BUS_W-2];
   assign cyc_write  = sync2_reg[BUS_W-3];
   assign cyc_addr   = sync2_reg[WDATA_W +: ADDR_W];
   assign cyc_wdata  = sync2_reg[WDATA_W-1:0];
   assign cyc_sect   = cyc_addr[SECT_LSB +: SECT_W];
   assign wr_cyc     = edge_valid & cyc_write;
   assign rd_cyc     = edge_valid & ~cyc_write;

   // Guard bit program decode for the addressed sector
   assign set_hit = wr_cyc && seq_reg == SQ_PROG && mode_reg == MODE_DYN
                    && cyc_wdata == GUARD_SET_DATA;
   assign clr_hit = wr_cyc && seq_reg == SQ_PROG && mode_reg == MODE_DYN
                    && cyc_wdata == GUARD_CLR_DATA;

   // Status word of the addressed sector; stored 1 means protected
   always_comb
   begin
      status_word                        = RDATA_RESET;
      status_word[ST_DYN_BIT]            = ~dyn_reg[cyc_sect];
      status_word[ST_PERS_BIT]           = ~pers_guard_in[cyc_sect];
      // Either source alone is enough to report the sector protected
      status_word[ST_ANY_BIT]            = ~(dyn_reg[cyc_sect]
                                             | pers_guard_in[cyc_sect]);
   end

   // Command sequencer: unlock keys, program prefix, status prefix
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         seq_reg <= SQ_IDLE;
      else if (rd_cyc)
         seq_reg <= SQ_IDLE;
      else if (wr_cyc)
      begin
         case (seq_reg)
            SQ_IDLE:
            begin
               if (cyc_wdata == KEY1_CODE)
                  seq_reg <= SQ_KEY1;
               else if (cyc_wdata == STATUS_CODE)
                  seq_reg <= SQ_STATUS;
               else if (cyc_wdata == PROG_CODE && mode_reg != MODE_ARRAY)
                  seq_reg <= SQ_PROG;
               else
                  seq_reg <= SQ_IDLE;
            end
            SQ_KEY1:
               seq_reg <= (cyc_wdata == KEY2_CODE) ? SQ_KEY2 : SQ_IDLE;
            default:
               seq_reg <= SQ_IDLE;
         endcase
      end
   end

   // Overlay mode; entry address is never looked at
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         mode_reg <= MODE_ARRAY;
      else if (wr_cyc && seq_reg == SQ_IDLE && cyc_wdata == EXIT_CODE)
         mode_reg <= MODE_ARRAY;
      else if (wr_cyc && seq_reg == SQ_KEY2)
      begin
         case (cyc_wdata)
            LOCK_ENT_CODE: mode_reg <= MODE_LOCK;
            DYN_ENT_CODE:  mode_reg <= MODE_DYN;
            PERS_ENT_CODE: mode_reg <= MODE_PERS;
            default:       mode_reg <= mode_reg;
         endcase
      end
   end

   // Volatile lock: only a clear exists, reset re-arms it
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         lock_reg <= LOCK_RESET;
      else if (wr_cyc && seq_reg == SQ_PROG && mode_reg == MODE_LOCK
               && cyc_wdata == LOCK_CLR_DATA)
         lock_reg <= 1'b0;
   end

   // Per-sector volatile guard bits
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SECT; gi++)
      begin : g_dyn
         always_ff @(posedge core_clk_in or negedge nrst_in)
         begin
            if (!nrst_in)
               dyn_reg[gi] <= DYN_RESET[gi];
            else if (set_hit && cyc_sect == SECT_W'(gi))
               dyn_reg[gi] <= 1'b1;
            else if (clr_hit && cyc_sect == SECT_W'(gi))
               dyn_reg[gi] <= 1'b0;
         end
      end
   endgenerate

   // Array address for the outside store; data returns one cycle later
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         array_addr_out <= '0;
         fetch_reg      <= 1'b0;
      end
      else
      begin
         fetch_reg <= rd_cyc && mode_reg == MODE_ARRAY && seq_reg != SQ_STATUS;
         if (edge_valid)
            array_addr_out <= cyc_addr;
      end
   end

   // Read data: status, overlay bit in bit 0 with ones above, or array
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         rdata_reg <= RDATA_RESET;
      else if (fetch_reg)
         rdata_reg <= array_rdata_in;
      else if (rd_cyc)
      begin
         if (seq_reg == SQ_STATUS)
            rdata_reg <= status_word;
         else
         begin
            case (mode_reg)
               MODE_LOCK:
                  rdata_reg <= {RDATA_RESET[RDATA_W-1:1], lock_reg};
               MODE_DYN:
                  rdata_reg <= {RDATA_RESET[RDATA_W-1:1],
                                ~dyn_reg[cyc_sect]};
               MODE_PERS:
                  rdata_reg <= {RDATA_RESET[RDATA_W-1:1],
                                ~pers_guard_in[cyc_sect]};
               default:
                  rdata_reg <= rdata_reg;
            endcase
         end
      end
   end

   assign link.cyc_rdata                = rdata_reg;
   assign global_guard_lock_bit_out     = lock_reg;
   assign volatile_sector_guard_bit_out = dyn_reg;
   assign mode_out                      = mode_reg;

endmodule : spoa_device

// >>> rtl/spoa_host.sv
/*
 * Host end of the link: divides the core clock into the link clock and
 * turns one user request into one bus cycle, returning read data.
 * Assumes the device answers well within half a link clock period.
 */
`timescale 1ns/1ps
module spoa_host
   import spoa_pkg::*;
(
   input  wire logic                         core_clk_in,
   input  wire logic                         nrst_in,
   spoa_link_if.host_mp                      link,
   input  wire logic                         req_valid_in,
   input  wire logic                         req_write_in,
   input  wire logic [spoa_pkg::ADDR_W-1:0]  req_addr_in,
   input  wire logic [spoa_pkg::WDATA_W-1:0] req_wdata_in,
   output logic                              req_ready_out,
   output logic                              rsp_valid_out,
   output logic      [spoa_pkg::RDATA_W-1:0] rsp_data_out
);
   import spoa_pkg::*;

   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LINK_HALF_CYC - 1);

   logic [DIV_W-1:0]    div_reg;
   logic                lclk_reg;
   logic                fall_next;
   spoa_hstate_e        state_reg;
   logic                valid_reg;
   logic                write_reg;
   logic [ADDR_W-1:0]   addr_reg;
   logic [WDATA_W-1:0]  wdata_reg;
   logic                is_read_reg;
   logic [RDATA_W-1:0]  rd_s1_reg;
   logic [RDATA_W-1:0]  rd_s2_reg;

   // Free-running divider; link clock runs from reset onward
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         div_reg  <= '0;
         lclk_reg <= 1'b0;
      end
      else if (div_reg == DIV_LAST)
      begin
         div_reg  <= '0;
         lclk_reg <= ~lclk_reg;
      end
      else
         div_reg <= div_reg + 1'b1;
   end

   assign fall_next = (div_reg == DIV_LAST) & lclk_reg;

   // Answer comes from another module, so two flops before use
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rd_s1_reg <= '0;
         rd_s2_reg <= '0;
      end
      else
      begin
         rd_s1_reg <= link.cyc_rdata;
         rd_s2_reg <= rd_s1_reg;
      end
   end

   // Valid changes only at a falling edge, giving half a link period of setup
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state_reg     <= H_IDLE;
         req_ready_out <= 1'b1;
         rsp_valid_out <= 1'b0;
         rsp_data_out  <= '0;
         valid_reg     <= 1'b0;
         write_reg     <= 1'b0;
         addr_reg      <= '0;
         wdata_reg     <= '0;
         is_read_reg   <= 1'b0;
      end
      else
      begin
         rsp_valid_out <= 1'b0;
         case (state_reg)
            H_IDLE:
            begin
               if (req_valid_in && req_ready_out)
               begin
                  req_ready_out <= 1'b0;
                  write_reg     <= req_write_in;
                  addr_reg      <= req_addr_in;
                  wdata_reg     <= req_wdata_in;
                  is_read_reg   <= ~req_write_in;
                  state_reg     <= H_WAIT_LOW;
               end
            end
            H_WAIT_LOW:
            begin
               if (fall_next)
               begin
                  valid_reg <= 1'b1;
                  state_reg <= H_DRIVE;
               end
            end
            H_DRIVE:
            begin
               // Device answer has settled late in the high phase
               if (fall_next)
               begin
                  valid_reg     <= 1'b0;
                  rsp_valid_out <= is_read_reg;
                  rsp_data_out  <= rd_s2_reg;
                  req_ready_out <= 1'b1;
                  state_reg     <= H_IDLE;
               end
            end
            default:
               state_reg <= H_IDLE;
         endcase
      end
   end

   assign link.link_clk  = lclk_reg;
   assign link.cyc_valid = valid_reg;
   assign link.cyc_write = write_reg;
   assign link.cyc_addr  = addr_reg;
   assign link.cyc_wdata = wdata_reg;

endmodule : spoa_host

// >>> verif/spoa_link_assertions.sv
/* Checker on the link between host and device ends, with a small
   mirror of the command sequence. Assumes it sees the same link signals. */
`timescale 1ns/1ps
module spoa_link_assertions
   import spoa_pkg::*;
(
   input  wire logic                         core_clk_in,
   input  wire logic                         nrst_in,
   input  wire logic                         link_clk,
   input  wire logic                         cyc_valid,
   input  wire logic                         cyc_write,
   input  wire logic [spoa_pkg::ADDR_W-1:0]  cyc_addr,
   input  wire logic [spoa_pkg::WDATA_W-1:0] cyc_wdata,
   input  wire logic [spoa_pkg::RDATA_W-1:0] cyc_rdata
);
   import spoa_pkg::*;

   logic        lc_q;
   logic [1:0]  mode_m;
   logic [2:0]  pfx_m;
   logic        lock_m;
   logic [15:0] vol_m;
   logic [3:0]  rd_age;
   logic        lr;
   logic        rd_ev;
   logic        st_rd;
   logic [3:0]  sect;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);

   // Cycle events seen at the link rise
   assign lr    = link_clk & ~lc_q & cyc_valid;
   assign rd_ev = lr & ~cyc_write;
   assign st_rd = rd_ev & (pfx_m == 3'h4);
   assign sect  = cyc_addr[7:4];

   // Link clock edge finder
   always_ff @(posedge core_clk_in or negedge nrst_in)
      if (!nrst_in)
         lc_q <= 1'b0;
      else
         lc_q <= link_clk;

   // Cycles since the last read, saturating
   always_ff @(posedge core_clk_in or negedge nrst_in)
      if (!nrst_in)
         rd_age <= 4'hF;
      else if (rd_ev)
         rd_age <= 4'h0;
      else if (rd_age != 4'hF)
         rd_age <= rd_age + 4'h1;

   // Mirror of the sequence; a read drops any pending prefix
   always_ff @(posedge core_clk_in or negedge nrst_in)
      if (!nrst_in)
      begin
         pfx_m  <= 3'h0;
         mode_m <= 2'h0;
         lock_m <= 1'b1;
         vol_m  <= 16'h0000;
      end
      else if (rd_ev)
         pfx_m <= 3'h0;
      else if (lr)
      begin
         pfx_m <= 3'h0;
         case (pfx_m)
            3'h0:
            begin
               if (cyc_wdata == KEY1_CODE) pfx_m <= 3'h1;
               if (cyc_wdata == PROG_CODE) pfx_m <= 3'h3;
               if (cyc_wdata == STATUS_CODE) pfx_m <= 3'h4;
               if (cyc_wdata == EXIT_CODE) mode_m <= 2'h0;
            end
            3'h1: if (cyc_wdata == KEY2_CODE) pfx_m <= 3'h2;
            3'h2:
            begin
               if (cyc_wdata == LOCK_ENT_CODE) mode_m <= 2'h1;
               if (cyc_wdata == DYN_ENT_CODE) mode_m <= 2'h2;
               if (cyc_wdata == PERS_ENT_CODE) mode_m <= 2'h3;
            end
            3'h3:
            begin
               if (mode_m == 2'h1 && cyc_wdata == LOCK_CLR_DATA) lock_m <= 1'b0;
               if (mode_m == 2'h2 && cyc_wdata == GUARD_SET_DATA) vol_m[sect] <= 1'b1;
               if (mode_m == 2'h2 && cyc_wdata == GUARD_CLR_DATA) vol_m[sect] <= 1'b0;
            end
            default: ;
         endcase
      end

   a_link_half: assert property (
      $rose(link_clk) |=> link_clk [*7] ##1 !link_clk)
      else $error("link clock high phase not eight cycles");
   a_fields_hold: assert property (
      lr |-> $stable(cyc_addr) && $stable(cyc_wdata) && $stable(cyc_write))
      else $error("cycle fields moved at link rise");
   a_valid_edge: assert property (
      $changed(cyc_valid) |-> $fell(link_clk))
      else $error("cycle valid moved off a link fall");
   a_status_ones: assert property (
      st_rd |-> ##6 cyc_rdata[15:3] == 13'h1FFF)
      else $error("status upper bits not ones");
   a_status_any: assert property (
      st_rd |-> ##6 cyc_rdata[0] == (cyc_rdata[1] & cyc_rdata[2]))
      else $error("status bit 0 disagrees with sources");
   a_status_dyn: assert property (
      st_rd |-> ##6 cyc_rdata[1] == !vol_m[sect])
      else $error("status bit 1 wrong");
   a_lock_word: assert property (
      rd_ev && pfx_m == 3'h0 && mode_m == 2'h1 |-> ##6 cyc_rdata == {15'h7FFF, lock_m})
      else $error("lock overlay word wrong");
   a_dyn_word: assert property (
      rd_ev && pfx_m == 3'h0 && mode_m == 2'h2 |-> ##6 cyc_rdata == {15'h7FFF, !vol_m[sect]})
      else $error("volatile overlay word wrong");
   a_pers_word: assert property (
      rd_ev && pfx_m == 3'h0 && mode_m == 2'h3 |-> ##6 cyc_rdata[15:1] == 15'h7FFF)
      else $error("persistent overlay upper bits wrong");
   a_rdata_hold: assert property (
      $changed(cyc_rdata) |-> rd_age <= 4'h6)
      else $error("read data moved without a read");
endmodule : spoa_link_assertions

// >>> verif/tb_top.sv
/* Bench joining host and device ends over the link, driven through the
   host request port. Assumes a simple array model on the device side. */
`timescale 1ns/1ps
module tb_top;
   import spoa_pkg::*;

   logic        core_clk_in;
   logic        nrst_in;
   logic        req_valid;
   logic        req_write;
   logic        req_ready;
   logic        rsp_valid;
   logic [7:0]  req_addr;
   logic [7:0]  req_wdata;
   logic [15:0] rsp_data;
   logic [15:0] pers_guard;
   logic [15:0] array_rdata;
   logic [15:0] vol_out;
   logic [15:0] vol_e;
   logic [15:0] rd_val;
   logic [7:0]  array_addr;
   logic        lock_out;
   logic [1:0]  mode_out;
   int          error_cnt;
   int          compares;
   int          cyc_cnt;

   spoa_link_if spoa_link_if_inst ();

   spoa_host spoa_host_inst (.core_clk_in, .nrst_in, .link(spoa_link_if_inst),
      .req_valid_in(req_valid), .req_write_in(req_write), .req_addr_in(req_addr),
      .req_wdata_in(req_wdata), .req_ready_out(req_ready), .rsp_valid_out(rsp_valid),
      .rsp_data_out(rsp_data));

   spoa_device spoa_device_inst (.core_clk_in, .nrst_in, .link(spoa_link_if_inst),
      .pers_guard_in(pers_guard), .array_rdata_in(array_rdata),
      .array_addr_out(array_addr), .global_guard_lock_bit_out(lock_out),
      .volatile_sector_guard_bit_out(vol_out), .mode_out(mode_out));

   spoa_link_assertions spoa_link_assertions_inst (.core_clk_in, .nrst_in,
      .link_clk(spoa_link_if_inst.link_clk), .cyc_valid(spoa_link_if_inst.cyc_valid),
      .cyc_write(spoa_link_if_inst.cyc_write), .cyc_addr(spoa_link_if_inst.cyc_addr),
      .cyc_wdata(spoa_link_if_inst.cyc_wdata), .cyc_rdata(spoa_link_if_inst.cyc_rdata));

   // Array model: tag byte above the address, easy to tell from overlays
   assign array_rdata = {8'hA5, array_addr};

   // 40 MHz core clock
   initial
   begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end

   // Hang guard, well above the few thousand cycles the tests need
   always @(posedge core_clk_in)
   begin
      cyc_cnt++;
      if (cyc_cnt == 20000)
      begin
         error_cnt++;
         conclude();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // One bus cycle; request held until ready seen, reads wait for the pulse
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk_in);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr  <= a;
      req_wdata <= d;
      do
      begin
         @(posedge core_clk_in);
         n++;
      end
      while (req_ready !== 1'b1 && n < 100);
      req_valid <= 1'b0;
      // Writes end when ready returns, reads at the response pulse
      do
      begin
         @(posedge core_clk_in);
         n++;
      end
      while ((w ? req_ready : rsp_valid) !== 1'b1 && n < 100);
      rd_val = rsp_data;
      chk(n < 100, 16'h1);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      xfer(1'b0, a, 8'h00);
      chk(rd_val, exp);
   endtask : rdc

   // Entry keys carry junk addresses: the overlay must not use them
   task automatic enter(input logic [7:0] code);
      wr(8'h5A, KEY1_CODE);
      wr(8'hA5, KEY2_CODE);
      wr(8'hC3, code);
   endtask : enter

   task automatic qry(input logic [3:0] s);
      wr(8'h00, STATUS_CODE);
      rdc({s, 4'h9}, {13'h1FFF, ~pers_guard[s], ~vol_e[s], ~(pers_guard[s] | vol_e[s])});
   endtask : qry

   task automatic conclude();
      if (error_cnt == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   // Main sequence
   initial
   begin
      error_cnt = 0;
      compares = 0;
      cyc_cnt = 0;
      nrst_in = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 8'h00;
      req_wdata = 8'h00;
      pers_guard = 16'h0012;
      vol_e = 16'h0000;
      repeat (6) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      rdc(8'h37, 16'hA537);
      for (int s = 0; s < 16; s++) qry(s[3:0]);
      // Lock overlay: read anywhere, clear, exit
      enter(LOCK_ENT_CODE);
      chk(mode_out, 16'h1);
      rdc(8'h00, 16'hFFFF);
      rdc(8'hE7, 16'hFFFF);
      wr(8'h42, PROG_CODE);
      wr(8'h42, LOCK_CLR_DATA);
      chk(lock_out, 16'h0);
      rdc(8'h91, 16'hFFFE);
      wr(8'h00, EXIT_CODE);
      chk(mode_out, 16'h0);
      rdc(8'h91, 16'hA591);
      // Volatile overlay: set three sectors, clear one back
      enter(DYN_ENT_CODE);
      chk(mode_out, 16'h2);
      foreach (vol_e[i]) if (i == 5 || i == 15 || i == 2)
      begin
         wr({i[3:0], 4'hB}, PROG_CODE);
         wr({i[3:0], 4'hB}, GUARD_SET_DATA);
      end
      wr(8'h2C, PROG_CODE);
      wr(8'h2C, GUARD_CLR_DATA);
      vol_e = 16'h8020;
      chk(vol_out, vol_e);
      rdc(8'h5E, 16'hFFFE);
      rdc(8'hF0, 16'hFFFE);
      rdc(8'h2C, 16'hFFFF);
      for (int s = 0; s < 16; s++) qry(s[3:0]);
      rdc(8'h50, 16'hFFFE);
      wr(8'h00, EXIT_CODE);
      // Persistent overlay follows the live guard input
      enter(PERS_ENT_CODE);
      chk(mode_out, 16'h3);
      rdc(8'h1A, 16'hFFFE);
      rdc(8'h23, 16'hFFFF);
      pers_guard <= 16'h0004;
      rdc(8'h23, 16'hFFFE);
      wr(8'h00, EXIT_CODE);
      // A read between keys cancels the entry
      wr(8'h00, KEY1_CODE);
      rdc(8'h44, 16'hA544);
      wr(8'h00, KEY2_CODE);
      wr(8'h00, LOCK_ENT_CODE);
      chk(mode_out, 16'h0);
      // Reset in mid-run restores array read and guard defaults
      enter(DYN_ENT_CODE);
      nrst_in <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      chk(mode_out, 16'h0);
      chk(vol_out, 16'h0);
      chk(lock_out, 16'h1);
      nrst_in <= 1'b1;
      rdc(8'h12, 16'hA512);
      conclude();
   end
endmodule : tb_top
